// ===== include/chatter_params.svh
// Constants of the binary input chatter blocker
`ifndef CHATTER_PARAMS_SVH
`define CHATTER_PARAMS_SVH
`define CB_N_IN 8
`define CB_CLK_NS 50
`define CB_SEC_NS 1000000000
`define CB_SEC_CYCLES (`CB_SEC_NS / `CB_CLK_NS)
`define CB_SEC_PER_MIN 60
`define CB_UNLIMITED 8'hFF
`define CB_PROT_MASK 8'h03
`define CB_IND_MID 2'h0
`define CB_IND_OFF 2'h1
`define CB_IND_ON 2'h2
`define CB_A_LIMIT 8'h00
`define CB_A_ITEST 8'h04
`define CB_A_TCOUNT 8'h08
`define CB_A_IDLE 8'h0C
`define CB_A_STEST 8'h10
`define CB_A_ENABLE 8'h14
`define CB_A_DPMODE 8'h18
`define CB_A_STATUS 8'h1C
`define CB_A_ISTAT 8'h20
`define CB_A_ICLR 8'h24
`define CB_A_IEN 8'h28
`define CB_A_IND 8'h2C
`define CB_RST_LIMIT 8'h04
`define CB_RST_ITEST 8'h02
`define CB_RST_TCOUNT 8'h03
`define CB_RST_IDLE 8'h01
`define CB_RST_STEST 8'h05
`endif

// ===== include/chatter_pkg.sv
// Types of the binary input chatter blocker
package chatter_pkg;
`include "chatter_params.svh"
   typedef enum logic [2:0] {S_WAIT, S_INIT, S_HOLD, S_RETEST, S_FINAL} chan_st_t;
   typedef struct packed {
      chan_st_t st;
      logic [7:0] trans;
      logic [7:0] cyc;
      logic [7:0] tmr;
      logic hold;
   } chan_t;
   typedef struct packed {
      logic [7:0] lim;
      logic [7:0] itest;
      logic [7:0] tcnt;
      logic [7:0] idle;
      logic [7:0] stest;
      logic [`CB_N_IN-1:0] en;
      logic [`CB_N_IN-1:0] dp;
   } cfg_t;
   typedef struct packed {
      logic [7:0] addr;
      logic wr_pend;
      logic rd_pend;
      logic ready;
      logic [31:0] rdata;
   } bus_t;
   typedef struct packed {
      chan_t [`CB_N_IN-1:0] ch;
      cfg_t cfg;
      bus_t bus;
      logic [`CB_N_IN-1:0] s1;
      logic [`CB_N_IN-1:0] s2;
      logic [`CB_N_IN-1:0] s3;
      logic [15:0] stat;
      logic [15:0] ien;
      logic [2*`CB_N_IN-1:0] ind;
      logic [`CB_N_IN-1:0] tag;
      logic common;
      logic ev;
      logic irq;
   } state_t;
endpackage : chatter_pkg

// ===== tb/binary_input_chatter_blocker_test.sv
// Self-checking testbench of the binary input chatter blocker
`timescale 1ns/1ns
`include "chatter_params.svh"
module binary_input_chatter_blocker_test;
   import chatter_pkg::*;
   // Short second keeps the one-minute idle near 1200 cycles
   localparam int SEC = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic go = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [7:0] cnt_n = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [2:0] ch = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic [7:0] bin_in, tag;
   logic [15:0] ind;
   logic busy, hreadyout, hresp, common, ev, irq;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int ev_n = 0;
   always #25 hclk = ~hclk;
   chatter_blocker #(.SEC_CYCLES(SEC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .bin_in(bin_in), .ind_code(ind), .chatter_block_tag(tag), .chatter_common(common),
      .chatter_event(ev), .irq(irq));
   contact_bank contacts_u (.hclk(hclk), .ch(ch), .n(cnt_n), .go(go), .bin_in(bin_in),
      .busy(busy));
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (ev === 1'b1) begin
         ev_n <= ev_n + 1;
      end
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Address phase held until ready, then data phase held until ready again
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask : rchk
   task automatic toggle(input logic [2:0] c, input logic [7:0] k);
      ch <= c;
      cnt_n <= k;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
      while (busy === 1'b1) @(posedge hclk);
   endtask : toggle
   task automatic wait_tag(input int c, input logic v, input int lim);
      for (int i = 0; i < lim && tag[c] !== v; i++) @(posedge hclk);
   endtask : wait_tag
   task automatic t_reset;
      rchk("limit", `CB_A_LIMIT, 32'h4);
      rchk("itest", `CB_A_ITEST, 32'h2);
      rchk("tcount", `CB_A_TCOUNT, 32'h3);
      rchk("idle", `CB_A_IDLE, 32'h1);
      rchk("stest", `CB_A_STEST, 32'h5);
      rchk("enable", `CB_A_ENABLE, 32'h0);
      rchk("ien", `CB_A_IEN, 32'h0);
      rchk("unmapped", 8'h30, 32'h0);
      chk("ind", 32'h5555, {16'h0, ind});
      chk("hresp", 32'h0, {31'h0, hresp});
      $display("test reset done");
   endtask : t_reset
   task automatic t_protect;
      wr(`CB_A_ENABLE, 32'hFF);
      rchk("enable", `CB_A_ENABLE, 32'hFC);
      wr(8'h30, 32'hFF);
      rchk("unmapped", 8'h30, 32'h0);
      $display("test protect done");
   endtask : t_protect
   task automatic t_pass;
      wr(`CB_A_LIMIT, 32'h2);
      wr(`CB_A_ENABLE, 32'h4);
      toggle(3'h3, 8'h05);
      wait_tag(3, 1'b1, 20);
      chk("tag3", 32'h0, {31'h0, tag[3]});
      chk("ind3", 32'h2, {30'h0, ind[7:6]});
      $display("test pass done");
   endtask : t_pass
   task automatic t_block;
      int n;
      n = ev_n;
      wr(`CB_A_IEN, 32'h4);
      toggle(3'h2, 8'h04);
      wait_tag(2, 1'b1, 20);
      chk("tag2", 32'h1, {31'h0, tag[2]});
      chk("common", 32'h1, {31'h0, common});
      chk("irq", 32'h1, {31'h0, irq});
      // Frozen at the level before the offending change, which was low
      chk("ind2", 32'h1, {30'h0, ind[5:4]});
      // Raw field still shows input 3 high from the pass-through test
      rchk("status", `CB_A_STATUS, 32'h00080004);
      chk("events", n + 1, ev_n);
      wr(`CB_A_ICLR, 32'h4);
      rchk("istat", `CB_A_ISTAT, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wait_tag(2, 1'b0, 1600);
      chk("tag2", 32'h0, {31'h0, tag[2]});
      chk("ind2", 32'h1, {30'h0, ind[5:4]});
      $display("test block done");
   endtask : t_block
   task automatic t_final;
      wr(`CB_A_TCOUNT, 32'h0);
      wr(`CB_A_IDLE, 32'h7);
      rchk("idle", `CB_A_IDLE, 32'h1);
      wr(`CB_A_STEST, 32'h9);
      rchk("stest", `CB_A_STEST, 32'h5);
      wr(`CB_A_LIMIT, 32'h3);
      wr(`CB_A_DPMODE, 32'h10);
      wr(`CB_A_ENABLE, 32'h30);
      toggle(3'h4, 8'h05);
      wait_tag(4, 1'b1, 20);
      chk("ind4", 32'h0, {30'h0, ind[9:8]});
      toggle(3'h5, 8'h05);
      wait_tag(5, 1'b1, 20);
      chk("ind5", 32'h2, {30'h0, ind[11:10]});
      bus(1'b0, `CB_A_STATUS, 32'h0);
      chk("final", 32'h30, {24'h0, rd[15:8]});
      wait_tag(4, 1'b0, 1600);
      chk("tag4", 32'h1, {31'h0, tag[4]});
      $display("test final done");
   endtask : t_final
   task automatic t_unlimited;
      wr(`CB_A_TCOUNT, 32'hFF);
      wr(`CB_A_LIMIT, 32'h2);
      wr(`CB_A_ENABLE, 32'h4);
      toggle(3'h2, 8'h03);
      wait_tag(2, 1'b1, 20);
      chk("tag2", 32'h1, {31'h0, tag[2]});
      bus(1'b0, `CB_A_STATUS, 32'h0);
      chk("final", 32'h0, {24'h0, rd[15:8]});
      $display("test unlimited done");
   endtask : t_unlimited
   task automatic t_limit0;
      wr(`CB_A_LIMIT, 32'h0);
      wr(`CB_A_ENABLE, 32'h40);
      toggle(3'h6, 8'h06);
      wait_tag(6, 1'b1, 20);
      chk("tag6", 32'h0, {31'h0, tag[6]});
      $display("test limit zero done");
   endtask : t_limit0
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_protect();
      t_pass();
      t_block();
      t_final();
      t_unlimited();
      t_limit0();
      results();
   end
endmodule : binary_input_chatter_blocker_test

// ===== tb/contact_bank.sv
// Switchgear contact model driving the binary inputs
`timescale 1ns/1ns
module contact_bank #(
   parameter int GAP = 8
) (
   input wire logic hclk,     // System clock
   input wire logic [2:0] ch, // Contact to bounce
   input wire logic [7:0] n,  // Number of state changes
   input wire logic go,       // Start request
   output logic [7:0] bin_in, // Contact levels
   output logic busy          // Bouncing in progress
);
   logic [7:0] left;
   logic [2:0] cur;
   int gap;
   initial begin
      bin_in = 8'h00;
      busy = 1'b0;
      left = 8'h00;
      cur = 3'h0;
      gap = 0;
   end
   // Levels move only after an edge, like a real contact seen by the sync stage
   always @(posedge hclk) begin
      if (go && !busy) begin
         left <= n;
         cur <= ch;
         busy <= (n != 8'h00);
         gap <= 0;
      end else if (busy) begin
         gap <= (gap == GAP - 1) ? 0 : gap + 1;
         if (gap == GAP - 1) begin
            bin_in[cur] <= ~bin_in[cur];
            left <= left - 8'h01;
            busy <= (left != 8'h01);
         end
      end
   end
endmodule : contact_bank

// ===== verilog/chatter_blocker.sv
// Binary input chatter blocker with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "chatter_params.svh"
module chatter_blocker
   import chatter_pkg::*;
#(
   parameter int SEC_CYCLES = `CB_SEC_CYCLES
) (
   input wire logic hclk,                        // System clock, 20 MHz
   input wire logic hresetn,                     // Async reset, active low
   input wire logic hsel,                        // Slave select
   input wire logic [7:0] haddr,                 // Byte address
   input wire logic [1:0] htrans,                // Transfer type
   input wire logic hwrite,                      // Write when high
   input wire logic [2:0] hsize,                 // Word transfers only
   input wire logic [31:0] hwdata,               // Write data
   input wire logic hready,                      // Bus ready
   output logic [31:0] hrdata,                   // Read data
   output logic hreadyout,                       // Slave ready
   output logic hresp,                           // Always OKAY
   input wire logic [`CB_N_IN-1:0] bin_in,       // Contact inputs, async
   output logic [2*`CB_N_IN-1:0] ind_code,       // Indication per input
   output logic [`CB_N_IN-1:0] chatter_block_tag, // Input blocked marker
   output logic chatter_common,                  // Any input blocked
   output logic chatter_event,                   // Pulse on tag change
   output logic irq                              // Level interrupt
);
   state_t r;
   state_t r_nxt;
   logic sec_tick;
   logic min_tick;
   logic [`CB_N_IN-1:0] edge_v;
   logic [`CB_N_IN-1:0] blk_v;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   chan_t c;
   logic [7:0] cnt;

   tick_base #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
      .hclk(hclk),
      .hresetn(hresetn),
      .sec_tick(sec_tick),
      .min_tick(min_tick)
   );

   function automatic logic is_blocked(input chan_st_t st);
      is_blocked = (st == S_HOLD) || (st == S_RETEST) || (st == S_FINAL);
   endfunction : is_blocked

   function automatic logic tmr_done(input logic [7:0] tmr, input logic [7:0] lim);
      tmr_done = ({1'b0, tmr} + 9'h001) >= {1'b0, lim};
   endfunction : tmr_done

   function automatic logic [1:0] ind_of(input logic blk, input logic dp, input logic hold);
      if (blk && dp) begin
         ind_of = `CB_IND_MID;
      end else begin
         ind_of = hold ? `CB_IND_ON : `CB_IND_OFF;
      end
   endfunction : ind_of

   function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] a);
      logic [`CB_N_IN-1:0] fin;
      logic [`CB_N_IN-1:0] blk;
      fin = '0;
      blk = '0;
      for (int k = 0; k < `CB_N_IN; k++) begin
         fin[k] = (s.ch[k].st == S_FINAL);
         blk[k] = is_blocked(s.ch[k].st);
      end
      unique case (a)
         `CB_A_LIMIT: rd_mux = {24'h0, s.cfg.lim};
         `CB_A_ITEST: rd_mux = {24'h0, s.cfg.itest};
         `CB_A_TCOUNT: rd_mux = {24'h0, s.cfg.tcnt};
         `CB_A_IDLE: rd_mux = {24'h0, s.cfg.idle};
         `CB_A_STEST: rd_mux = {24'h0, s.cfg.stest};
         `CB_A_ENABLE: rd_mux = {24'h0, s.cfg.en};
         `CB_A_DPMODE: rd_mux = {24'h0, s.cfg.dp};
         `CB_A_STATUS: rd_mux = {8'h0, s.s2, fin, blk};
         `CB_A_ISTAT: rd_mux = {16'h0, s.stat};
         `CB_A_IEN: rd_mux = {16'h0, s.ien};
         `CB_A_IND: rd_mux = {16'h0, s.ind};
         default: rd_mux = 32'h0;
      endcase
   endfunction : rd_mux

   always_comb begin
      r_nxt = r;
      set_v = 16'h0;
      clr_v = 16'h0;
      blk_v = '0;
      c = r.ch[0];
      cnt = 8'h0;
      // Two-stage synchroniser, third stage for edge detect
      r_nxt.s1 = bin_in;
      r_nxt.s2 = r.s1;
      r_nxt.s3 = r.s2;
      edge_v = r.s2 ^ r.s3;

      // Bus: writes take effect in the data phase, reads cost one wait state
      r_nxt.bus.ready = 1'b1;
      r_nxt.bus.wr_pend = 1'b0;
      r_nxt.bus.rd_pend = 1'b0;
      if (r.bus.wr_pend) begin
         unique case (r.bus.addr)
            `CB_A_LIMIT: r_nxt.cfg.lim = hwdata[7:0];
            `CB_A_ITEST: r_nxt.cfg.itest = hwdata[7:0];
            `CB_A_TCOUNT: r_nxt.cfg.tcnt = hwdata[7:0];
            `CB_A_IDLE: begin
               if (r.cfg.tcnt != 8'h00) begin
                  r_nxt.cfg.idle = hwdata[7:0];
               end
            end
            `CB_A_STEST: begin
               if (r.cfg.tcnt != 8'h00) begin
                  r_nxt.cfg.stest = hwdata[7:0];
               end
            end
            `CB_A_ENABLE: r_nxt.cfg.en = hwdata[`CB_N_IN-1:0] & ~`CB_PROT_MASK;
            `CB_A_DPMODE: r_nxt.cfg.dp = hwdata[`CB_N_IN-1:0];
            `CB_A_ICLR: clr_v = hwdata[15:0];
            `CB_A_IEN: r_nxt.ien = hwdata[15:0];
            default: ;
         endcase
      end
      if (r.bus.rd_pend) begin
         r_nxt.bus.rdata = rd_mux(r, r.bus.addr);
      end
      if (hsel && htrans[1] && hready) begin
         r_nxt.bus.addr = haddr;
         if (hwrite) begin
            r_nxt.bus.wr_pend = 1'b1;
         end else begin
            r_nxt.bus.rd_pend = 1'b1;
            r_nxt.bus.ready = 1'b0;
         end
      end

      // One state machine per input, all timed from the shared ticks
      for (int i = 0; i < `CB_N_IN; i++) begin
         c = r.ch[i];
         cnt = (c.trans == 8'hFF) ? 8'hFF : c.trans + {7'h0, edge_v[i]};
         if (!r.cfg.en[i] || r.cfg.lim == 8'h00) begin
            c.st = S_WAIT;
            c.trans = 8'h0;
            c.cyc = 8'h0;
            c.tmr = 8'h0;
         end else begin
            unique case (c.st)
               S_WAIT: begin
                  if (r.s2[i] && !r.s3[i]) begin
                     c.st = S_INIT;
                     c.trans = 8'h01;
                     c.tmr = 8'h0;
                  end
               end
               S_INIT, S_RETEST: begin
                  c.trans = cnt;
                  if (cnt > r.cfg.lim) begin
                     if (r.cfg.tcnt != `CB_UNLIMITED && c.cyc >= r.cfg.tcnt) begin
                        c.st = S_FINAL;
                     end else begin
                        c.st = S_HOLD;
                        c.cyc = c.cyc + 8'h01;
                        c.tmr = 8'h0;
                     end
                  end else if (sec_tick) begin
                     if (tmr_done(c.tmr, (c.st == S_INIT) ? r.cfg.itest : r.cfg.stest)) begin
                        c.st = S_WAIT;
                        c.cyc = 8'h0;
                     end else begin
                        c.tmr = c.tmr + 8'h01;
                     end
                  end
               end
               S_HOLD: begin
                  if (min_tick) begin
                     if (tmr_done(c.tmr, r.cfg.idle)) begin
                        c.st = S_RETEST;
                        c.trans = 8'h0;
                        c.tmr = 8'h0;
                     end else begin
                        c.tmr = c.tmr + 8'h01;
                     end
                  end
               end
               S_FINAL: ;
            endcase
         end
         blk_v[i] = is_blocked(c.st);
         // Single-point indication frozen at the last state seen before blocking, double-point goes to intermediate
         if (!blk_v[i]) begin
            c.hold = r.s2[i];
         end
         set_v[i] = blk_v[i] && !r.tag[i];
         set_v[`CB_N_IN + i] = (c.st == S_FINAL) && (r.ch[i].st != S_FINAL);
         r_nxt.ind[2*i +: 2] = ind_of(blk_v[i], r.cfg.dp[i], c.hold);
         r_nxt.ch[i] = c;
      end

      r_nxt.tag = blk_v;
      r_nxt.common = |blk_v;
      r_nxt.ev = (blk_v != r.tag);
      // Set wins over a clear in the same cycle
      r_nxt.stat = (r.stat & ~clr_v) | set_v;
      r_nxt.irq = |(r_nxt.stat & r_nxt.ien);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.cfg.lim <= `CB_RST_LIMIT;
         r.cfg.itest <= `CB_RST_ITEST;
         r.cfg.tcnt <= `CB_RST_TCOUNT;
         r.cfg.idle <= `CB_RST_IDLE;
         r.cfg.stest <= `CB_RST_STEST;
         r.bus.ready <= 1'b1;
         r.ind <= {`CB_N_IN{`CB_IND_OFF}};
      end else begin
         r <= r_nxt;
      end
   end

   assign hrdata = r.bus.rdata;
   assign hreadyout = r.bus.ready;
   assign hresp = 1'b0;
   assign ind_code = r.ind;
   assign chatter_block_tag = r.tag;
   assign chatter_common = r.common;
   assign chatter_event = r.ev;
   assign irq = r.irq;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic wr_idle_h;
   logic wr_stest_h;
   assign wr_idle_h = r.bus.wr_pend && (r.bus.addr == `CB_A_IDLE);
   assign wr_stest_h = r.bus.wr_pend && (r.bus.addr == `CB_A_STEST);

   a_zero_limit_off: assert property ((r.cfg.lim == 8'h00) |=> (chatter_block_tag == '0))
      else $error("input blocked with limit zero");
   a_disabled_pass: assert property (!r.cfg.en[2] |=> !chatter_block_tag[2])
      else $error("disabled input blocked");
   a_count_within: assert property ((r.ch[2].st == S_INIT && $stable(r.cfg.lim))
      |-> (r.ch[2].trans <= r.cfg.lim))
      else $error("count above limit without block");
   a_unlimited_final: assert property ((r.cfg.tcnt == `CB_UNLIMITED && r.ch[2].st != S_FINAL)
      |=> (r.ch[2].st != S_FINAL))
      else $error("final block with unlimited tests");
   a_idle_guard: assert property ((wr_idle_h && r.cfg.tcnt == 8'h00) |=> $stable(r.cfg.idle))
      else $error("idle time taken with zero tests");
   a_retest_guard: assert property ((wr_stest_h && r.cfg.tcnt == 8'h00)
      |=> $stable(r.cfg.stest))
      else $error("retest time taken with zero tests");
   a_prot_never_en: assert property ((r.cfg.en & `CB_PROT_MASK) == '0)
      else $error("protection input enabled");
   a_common_tag: assert property (chatter_common == (|chatter_block_tag))
      else $error("common flag disagrees with tags");
   a_dp_middle: assert property ((chatter_block_tag[4] && r.cfg.dp[4])
      |-> (ind_code[9:8] == `CB_IND_MID))
      else $error("double point not intermediate");
   a_sp_frozen: assert property ((chatter_block_tag[2] && !r.cfg.dp[2]
      && $past(chatter_block_tag[2]) && !$past(r.cfg.dp[2]))
      |-> (ind_code[5:4] == $past(ind_code[5:4])))
      else $error("single point moved while blocked");
   a_hold_to_final: assert property ((r.ch[2].st == S_HOLD) |=> (r.ch[2].st != S_FINAL))
      else $error("idle interval skipped");
   a_irq_level: assert property (irq == (|(r.stat & r.ien)))
      else $error("interrupt disagrees with status");

   c_block: cover property (r.ch[2].st == S_INIT ##1 r.ch[2].st == S_HOLD);
   c_final: cover property (r.ch[2].st == S_RETEST ##1 r.ch[2].st == S_FINAL);
   c_release: cover property (r.ch[2].st == S_RETEST ##1 r.ch[2].st == S_WAIT);
endmodule : chatter_blocker

// ===== verilog/tick_base.sv
// Seconds and minutes tick generator
`timescale 1ns/1ns
`include "chatter_params.svh"
module tick_base
   import chatter_pkg::*;
#(
   parameter int SEC_CYCLES = 20000000
) (
   input wire logic hclk,      // System clock
   input wire logic hresetn,   // Async reset, active low
   output logic sec_tick,      // One-cycle pulse each second
   output logic min_tick       // One-cycle pulse each minute
);
   typedef struct packed {
      logic [31:0] cnt;
      logic [5:0] secs;
      logic sec;
      logic min;
   } tick_t;

   tick_t r;
   tick_t r_nxt;

   always_comb begin
      r_nxt = r;
      r_nxt.sec = 1'b0;
      r_nxt.min = 1'b0;
      if (r.cnt == 32'(SEC_CYCLES - 1)) begin
         r_nxt.cnt = 32'h0;
         r_nxt.sec = 1'b1;
         if (r.secs == 6'(`CB_SEC_PER_MIN - 1)) begin
            r_nxt.secs = 6'h0;
            r_nxt.min = 1'b1;
         end else begin
            r_nxt.secs = r.secs + 6'h1;
         end
      end else begin
         r_nxt.cnt = r.cnt + 32'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign sec_tick = r.sec;
   assign min_tick = r.min;
endmodule : tick_base
